/* File: rtl/oma_pkg.sv */
package oma_pkg;
  // Array shape
  localparam int NUM_CELLS  = 8;   // Output logic macrocells
  localparam int NUM_DED    = 12;  // Dedicated array inputs
  localparam int NUM_SIG    = 20;  // Dedicated inputs plus one feedback slot per cell
  localparam int NUM_TERMS  = 64;  // Eight product terms per cell
  localparam int CELL_TERMS = 8;

  // Register byte offsets
  localparam logic [11:0] ADDR_MODE      = 12'h000;
  localparam logic [11:0] ADDR_POL       = 12'h004;
  localparam logic [11:0] ADDR_CFG       = 12'h008;
  localparam logic [11:0] ADDR_TDIS_LO   = 12'h00C;
  localparam logic [11:0] ADDR_TDIS_HI   = 12'h010;
  localparam logic [11:0] ADDR_STATUS    = 12'h014;
  localparam logic [11:0] ADDR_PRELOAD   = 12'h018;
  localparam logic [11:0] ADDR_SIG_LO    = 12'h01C;
  localparam logic [11:0] ADDR_SIG_HI    = 12'h020;
  localparam logic [11:0] ADDR_TERM_BASE = 12'h100;
  localparam logic [11:0] ADDR_TERM_LAST = 12'h2FC;

  // Field positions
  localparam int MODE_SYNC_BIT   = 0;  // global_sync_select_bit
  localparam int MODE_ARCH_BIT   = 1;  // global_arch_select_bit
  localparam int STAT_Q_LSB      = 0;
  localparam int STAT_OUT_LSB    = 8;
  localparam int STAT_OE_LSB     = 16;
  localparam int STAT_MODE_LSB   = 24;
  localparam int PRE_VAL_LSB     = 0;
  localparam int PRE_SEL_LSB     = 8;
  localparam int TERM_WORD_BIT   = 2;  // 0 true mask word, 1 complement mask word

  // Reset values
  localparam logic [1:0]  MODE_RST = 2'h0;
  localparam logic [7:0]  POL_RST  = 8'h00;
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [63:0] TDIS_RST = 64'h0;
  localparam logic [63:0] SIG_RST  = 64'h0;

  // Decoded global mode, one-hot
  typedef enum logic [2:0] {
    MODE_REG  = 3'b001,
    MODE_CPLX = 3'b010,
    MODE_SIMP = 3'b100
  } mode_t;

  // Per-cell architecture bits
  typedef struct packed {
    logic pol;  // Output polarity
    logic cfg;  // cell_io_config_bit
  } cellCtrl_t;

  // Per-pin driver
  typedef struct packed {
    logic out;
    logic oe;
  } pinDrive_t;

  // One product term's connection fuses
  typedef struct packed {
    logic [NUM_SIG-1:0] trueMask;
    logic [NUM_SIG-1:0] compMask;
  } termMask_t;
endpackage : oma_pkg

/* File: rtl/product_term_array.sv */
`timescale 1ns/100ps
module product_term_array
  import oma_pkg::*;
(
  // Array signals
  input  logic [NUM_SIG-1:0]   sig,
  // Fuse map
  input  termMask_t            masks [NUM_TERMS],
  input  logic [NUM_TERMS-1:0] termDis,
  // Term results
  output logic [NUM_TERMS-1:0] term
);
  // One AND gate per term; a disabled term is forced low
  for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
    assign term[t] = !termDis[t]
                   && ((masks[t].trueMask & ~sig) == '0)
                   && ((masks[t].compMask & sig) == '0);
  end
endmodule : product_term_array

/* File: rtl/macrocell.sv */
`timescale 1ns/100ps
module macrocell
  import oma_pkg::*;
#(
  parameter bit CENTRE = 1'b0  // Centre cells are always outputs in simple mode
) (
  // Clock and reset
  input  logic                  mclk,
  input  logic                  srst,
  // Configuration
  input  mode_t                 mode,
  input  cellCtrl_t             ctrl,
  // Array terms for this cell
  input  logic [CELL_TERMS-1:0] terms,
  // Shared controls
  input  logic                  regClkEdge,
  input  logic                  sharedOeN,
  input  logic                  preloadEn,
  input  logic                  preloadVal,
  // Results
  output pinDrive_t             drive,
  output logic                  q
);
  logic next_q;     // Register next state
  logic sumAll;     // OR of all eight terms
  logic sumLow;     // OR of terms 1..7; term 0 kept for enable

  // Register next state and pin driver
  always_comb begin
    sumAll = |terms;
    sumLow = |terms[CELL_TERMS-1:1];
    next_q = q;
    if (preloadEn) begin
      next_q = preloadVal;
    end else if (mode == MODE_REG && !ctrl.cfg && regClkEdge) begin
      next_q = sumAll ^ ctrl.pol;
    end
    case (mode)
      MODE_REG: begin
        if (!ctrl.cfg) begin
          // Inverting output buffer: cleared register shows high
          drive = '{out: !q, oe: !sharedOeN};
        end else begin
          drive = '{out: sumLow ^ ctrl.pol, oe: terms[0]};
        end
      end
      MODE_CPLX: begin
        drive = '{out: sumLow ^ ctrl.pol, oe: terms[0]};
      end
      MODE_SIMP: begin
        // Driver is never tri-stated by logic, only by input use
        drive = '{out: sumAll ^ ctrl.pol, oe: CENTRE || !ctrl.cfg};
      end
      default: begin
        drive = '{out: 1'b0, oe: 1'b0};
      end
    endcase
  end

  // Cell register, cleared by reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end
endmodule : macrocell

/* File: rtl/output_macrocell_array.sv */
`timescale 1ns/100ps
module output_macrocell_array
  import oma_pkg::*;
(
  // Clock and reset
  input  logic                 mclk,
  input  logic                 srst,
  // APB slave
  input  logic                 psel,
  input  logic                 penable,
  input  logic                 pwrite,
  input  logic [11:0]          paddr,
  input  logic [31:0]          pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Device pins
  input  logic [NUM_DED-1:0]   dedIn,
  input  logic                 specClkPin,
  input  logic                 specOePinN,
  input  logic [NUM_CELLS-1:0] ioIn,
  output logic [NUM_CELLS-1:0] ioOut,
  output logic [NUM_CELLS-1:0] ioOe
);
  localparam int SYNC_W = NUM_DED + 2 + NUM_CELLS;

  // Pin synchronisers; stage one feeds stage two only
  logic [SYNC_W-1:0]    syncA;
  logic [SYNC_W-1:0]    syncB;
  logic                 clkPrev;     // Last synced clock pin level
  logic [NUM_DED-1:0]   dedS;
  logic                 spClkS;
  logic                 spOeNS;
  logic [NUM_CELLS-1:0] pinS;
  logic                 regClkEdge;  // Rising edge of the clock pin

  // Configuration state
  logic [1:0]           modeBits;
  logic [7:0]           polBits;
  logic [7:0]           cfgBits;
  logic [63:0]          termDis;     // product_term_disable_fuse
  logic [63:0]          sigFuses;    // user_signature_fuses
  termMask_t            masks [NUM_TERMS];
  logic [7:0]           preSel;      // One-cycle preload strobe per cell
  logic [7:0]           preVal;
  logic [1:0]           next_modeBits;
  logic [7:0]           next_polBits;
  logic [7:0]           next_cfgBits;
  logic [63:0]          next_termDis;
  logic [63:0]          next_sigFuses;
  termMask_t            next_masks [NUM_TERMS];
  logic [7:0]           next_preSel;
  logic [7:0]           next_preVal;

  // Bus answer state
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;
  logic                 commit;      // Edge where the master sees pready
  logic                 termHit;
  logic                 hit;
  logic [11:0]          termOff;
  logic [5:0]           termIdx;
  logic [31:0]          rdData;

  // Array datapath
  mode_t                mode;
  logic [NUM_CELLS-1:0] slot;        // Feedback slots into the array
  logic [NUM_SIG-1:0]   sig;
  logic [NUM_TERMS-1:0] term;
  logic [NUM_CELLS-1:0] q;
  pinDrive_t            drive [NUM_CELLS];
  logic [NUM_CELLS-1:0] next_ioOut;
  logic [NUM_CELLS-1:0] next_ioOe;

  assign dedS       = syncB[NUM_DED-1:0];
  assign spClkS     = syncB[NUM_DED];
  assign spOeNS     = syncB[NUM_DED+1];
  assign pinS       = syncB[SYNC_W-1:NUM_DED+2];
  assign regClkEdge = spClkS && !clkPrev;

  // Mode decode from the two global bits
  always_comb begin
    if (!modeBits[MODE_SYNC_BIT]) begin
      mode = MODE_REG;
    end else if (modeBits[MODE_ARCH_BIT]) begin
      mode = MODE_CPLX;
    end else begin
      mode = MODE_SIMP;
    end
  end

  // Synchroniser and edge-detect flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      syncA   <= '0;
      syncB   <= '0;
      clkPrev <= 1'b0;
    end else begin
      syncA   <= {ioIn, specOePinN, specClkPin, dedIn};
      syncB   <= syncA;
      clkPrev <= spClkS;
    end
  end

  // Feedback routing and cells
  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    // Neighbour toward the outside; in simple mode centre pins are never read back
    localparam int NB = (i == 0 || i == NUM_CELLS-1) ? i : ((i < 4) ? i-1 : i+1);
    always_comb begin
      case (mode)
        MODE_REG: begin
          // Special pins never reach the array here
          slot[i] = cfgBits[i] ? pinS[i] : q[i];
        end
        MODE_CPLX: begin
          if (i == 0) begin
            slot[i] = spClkS;
          end else if (i == NUM_CELLS-1) begin
            slot[i] = !spOeNS;
          end else begin
            slot[i] = pinS[i];
          end
        end
        MODE_SIMP: begin
          if (i == 0) begin
            slot[i] = spClkS;
          end else if (i == NUM_CELLS-1) begin
            slot[i] = !spOeNS;
          end else begin
            slot[i] = pinS[NB];
          end
        end
        default: begin
          slot[i] = 1'b0;
        end
      endcase
    end

    macrocell #(
      .CENTRE (i == 3 || i == 4)
    ) u_cell (
      .mclk       (mclk),
      .srst       (srst),
      .mode       (mode),
      .ctrl       (cellCtrl_t'{pol: polBits[i], cfg: cfgBits[i]}),
      .terms      (term[i*CELL_TERMS +: CELL_TERMS]),
      .regClkEdge (regClkEdge),
      .sharedOeN  (spOeNS),
      .preloadEn  (preSel[i]),
      .preloadVal (preVal[i]),
      .drive      (drive[i]),
      .q          (q[i])
    );
    assign next_ioOut[i] = drive[i].out;
    assign next_ioOe[i]  = drive[i].oe;
  end

  assign sig = {slot, dedS};

  product_term_array u_array (
    .sig     (sig),
    .masks   (masks),
    .termDis (termDis),
    .term    (term)
  );

  // Address decode; the answer comes one cycle into the access phase
  assign commit  = psel && penable && pready;
  assign termOff = paddr - ADDR_TERM_BASE;
  assign termIdx = termOff[8:3];
  assign termHit = paddr >= ADDR_TERM_BASE && paddr <= ADDR_TERM_LAST && paddr[1:0] == 2'h0;
  always_comb begin
    hit = 1'b1;
    case (paddr)
      ADDR_MODE:    rdData = {30'h0, modeBits};
      ADDR_POL:     rdData = {24'h0, polBits};
      ADDR_CFG:     rdData = {24'h0, cfgBits};
      ADDR_TDIS_LO: rdData = termDis[31:0];
      ADDR_TDIS_HI: rdData = termDis[63:32];
      ADDR_STATUS:  rdData = {5'h0, mode, ioOe, ioOut, q};
      ADDR_PRELOAD: rdData = 32'h0;
      ADDR_SIG_LO:  rdData = sigFuses[31:0];
      ADDR_SIG_HI:  rdData = sigFuses[63:32];
      default: begin
        hit    = termHit;
        rdData = 32'h0;
        if (termHit) begin
          rdData[NUM_SIG-1:0] = termOff[TERM_WORD_BIT] ? masks[termIdx].compMask
                                                       : masks[termIdx].trueMask;
        end
      end
    endcase
  end

  // Register file next values; preload strobes last one cycle
  always_comb begin
    next_modeBits = modeBits;
    next_polBits  = polBits;
    next_cfgBits  = cfgBits;
    next_termDis  = termDis;
    next_sigFuses = sigFuses;
    next_masks    = masks;
    next_preSel   = 8'h00;
    next_preVal   = preVal;
    next_pready   = psel && penable && !pready;
    next_prdata   = prdata;
    next_pslverr  = 1'b0;
    if (next_pready) begin
      next_prdata  = rdData;
      next_pslverr = !hit;
    end
    if (commit && pwrite && hit) begin
      case (paddr)
        ADDR_MODE:   next_modeBits = pwdata[1:0];
        ADDR_POL:    next_polBits  = pwdata[7:0];
        ADDR_CFG:    next_cfgBits  = pwdata[7:0];
        ADDR_TDIS_LO: next_termDis[31:0]  = pwdata;
        ADDR_TDIS_HI: next_termDis[63:32] = pwdata;
        ADDR_PRELOAD: begin
          next_preSel = pwdata[PRE_SEL_LSB +: 8];
          next_preVal = pwdata[PRE_VAL_LSB +: 8];
        end
        ADDR_SIG_LO: next_sigFuses[31:0]  = pwdata;
        ADDR_SIG_HI: next_sigFuses[63:32] = pwdata;
        default: begin
          // Status is read-only; writes to it are dropped
          if (termHit && termOff[TERM_WORD_BIT]) begin
            next_masks[termIdx].compMask = pwdata[NUM_SIG-1:0];
          end else if (termHit) begin
            next_masks[termIdx].trueMask = pwdata[NUM_SIG-1:0];
          end
        end
      endcase
    end
  end

  // Register file, bus answer and pin output flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      modeBits <= MODE_RST;
      polBits  <= POL_RST;
      cfgBits  <= CFG_RST;
      termDis  <= TDIS_RST;
      sigFuses <= SIG_RST;
      masks    <= '{default: '0};
      preSel   <= 8'h00;
      preVal   <= 8'h00;
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      ioOut    <= 8'h00;
      ioOe     <= 8'h00;
    end else begin
      modeBits <= next_modeBits;
      polBits  <= next_polBits;
      cfgBits  <= next_cfgBits;
      termDis  <= next_termDis;
      sigFuses <= next_sigFuses;
      masks    <= next_masks;
      preSel   <= next_preSel;
      preVal   <= next_preVal;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      ioOut    <= next_ioOut;
      ioOe     <= next_ioOe;
    end
  end

  // Helper vectors for the checks below
  logic [NUM_CELLS-1:0] sumAllV;
  logic [NUM_CELLS-1:0] sumLowV;
  logic [NUM_CELLS-1:0] oeTermV;
  for (genvar k = 0; k < NUM_CELLS; k++) begin : g_help
    assign sumAllV[k] = |term[k*CELL_TERMS +: CELL_TERMS];
    assign sumLowV[k] = |term[k*CELL_TERMS+1 +: CELL_TERMS-1];
    assign oeTermV[k] = term[k*CELL_TERMS];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence preloadWrite;
    commit && pwrite && paddr == ADDR_PRELOAD;
  endsequence
  sequence strobeSeen;
    preSel == $past(pwdata[PRE_SEL_LSB +: 8]);
  endsequence

  mode_decode_a: assert property (
    commit && pwrite && paddr == ADDR_MODE |=>
      mode == (!$past(pwdata[0]) ? MODE_REG : ($past(pwdata[1]) ? MODE_CPLX : MODE_SIMP)))
    else $error("global bits decoded to wrong mode");
  no_special_reg_a: assert property (
    mode == MODE_REG |-> slot == ((cfgBits & pinS) | (~cfgBits & q)))
    else $error("special pin reached array in registered mode");
  shared_oe_a: assert property (
    mode == MODE_REG |=> (ioOe & ~$past(cfgBits)) == ({8{!$past(spOeNS)}} & ~$past(cfgBits)))
    else $error("registered output not gated by shared enable");
  reg_capture_a: assert property (
    regClkEdge && mode == MODE_REG && preSel == 8'h00 |=>
      (q & ~$past(cfgBits)) == (($past(sumAllV) ^ $past(polBits)) & ~$past(cfgBits)))
    else $error("register missed clock pin edge");
  complex_slot_a: assert property (
    mode == MODE_CPLX |-> slot[0] == spClkS && slot[7] == !spOeNS && slot[6:1] == pinS[6:1])
    else $error("complex mode feedback routing wrong");
  complex_drive_a: assert property (
    mode == MODE_CPLX |=> ioOe == $past(oeTermV) && ioOut == $past(sumLowV ^ polBits))
    else $error("complex mode output or enable wrong");
  simple_drive_a: assert property (
    mode == MODE_SIMP |=> ioOut == $past(sumAllV ^ polBits)
      && ioOe == ($past(~cfgBits) | 8'h18))
    else $error("simple mode driver wrong");
  io_term_oe_a: assert property (
    mode == MODE_REG |=> (ioOe & $past(cfgBits)) == ($past(oeTermV) & $past(cfgBits)))
    else $error("registered-mode io enable not from term");
  reset_clear_a: assert property (
    $fell(srst) |-> q == 8'h00 ##1 ((ioOut | ~ioOe) & ~cfgBits) == ~cfgBits || mode != MODE_REG)
    else $error("registers not clear after reset");
  preload_a: assert property (
    preloadWrite ##1 strobeSeen |=>
      (q & $past(preSel)) == ($past(preVal) & $past(preSel)))
    else $error("preload did not force registers");
endmodule : output_macrocell_array

/* File: dv/system_logic_model.sv */
`timescale 1ns/100ps
module system_logic_model
  import oma_pkg::*;
(
  // Clock
  input  logic                 mclk,
  // Requests from the bench
  input  logic                 clkReq,
  input  logic                 oeReqN,
  input  logic [NUM_DED-1:0]   dedReq,
  input  logic [NUM_CELLS-1:0] extVal,
  input  logic [NUM_CELLS-1:0] extEn,
  // Design pin drivers
  input  logic [NUM_CELLS-1:0] ioOut,
  input  logic [NUM_CELLS-1:0] ioOe,
  // Levels seen by the design
  output logic [NUM_DED-1:0]   dedIn,
  output logic                 specClkPin,
  output logic                 specOePinN,
  output logic [NUM_CELLS-1:0] ioIn
);
  // Pins move just after the edge; the clock pin idles low through reset so
  // no false edge follows it; the bench holds each clock level >= 3 cycles
  always @(posedge mclk) begin
    specClkPin <= clkReq;
    specOePinN <= oeReqN;
    dedIn      <= dedReq;
  end

  // Wire level: design driver wins, then our driver, else the pull-up reads high
  always_comb begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (ioOe[i]) begin
        ioIn[i] = ioOut[i];
      end else if (extEn[i]) begin
        ioIn[i] = extVal[i];
      end else begin
        ioIn[i] = 1'b1;
      end
    end
  end
endmodule : system_logic_model

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import oma_pkg::*;
;
  // Clock, reset and bus
  logic                 mclk    = 1'b0;
  logic                 srst    = 1'b1;
  logic                 psel    = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite  = 1'b0;
  logic [11:0]          paddr   = 12'h000;
  logic [31:0]          pwdata  = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  // Pins and far-side requests
  logic [NUM_DED-1:0]   dedIn;
  logic                 specClkPin;
  logic                 specOePinN;
  logic [NUM_CELLS-1:0] ioIn;
  logic [NUM_CELLS-1:0] ioOut;
  logic [NUM_CELLS-1:0] ioOe;
  logic                 clkReq  = 1'b0;
  logic                 oeReqN  = 1'b0;
  logic [NUM_CELLS-1:0] extVal  = 8'h00;
  logic [NUM_CELLS-1:0] extEn   = 8'h00;
  // Score
  int                   fails   = 0;
  int                   nTests  = 0;

  // 200 MHz clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  output_macrocell_array dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dedIn(dedIn), .specClkPin(specClkPin), .specOePinN(specOePinN),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

  system_logic_model far (.mclk(mclk), .clkReq(clkReq), .oeReqN(oeReqN),
    .dedReq(12'h5A3), .extVal(extVal), .extEn(extEn), .ioOut(ioOut), .ioOe(ioOe),
    .dedIn(dedIn), .specClkPin(specClkPin), .specOePinN(specOePinN), .ioIn(ioIn));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r       = prdata;
    e       = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never rewrites psel in this step
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  // Read, mask, compare data and error flag
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m,
                       input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r & m, exp);
    check({31'h0, e}, {31'h0, err});
  endtask : rdchk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // Clock pin pulse, each level well over the three-cycle minimum
  task automatic pulse;
    clkReq <= 1'b1;
    tick(4);
    clkReq <= 1'b0;
    tick(6);
  endtask : pulse

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Watchdog: the sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    tick(3);
    // Reset state: registered mode, cleared registers, pins high
    rdchk(ADDR_MODE, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rdchk(ADDR_CFG, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rdchk(ADDR_STATUS, 32'h01FF_FF00, 32'hFFFF_FFFF, 1'b0);
    rdchk(12'h024, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(ADDR_SIG_LO, 32'hA5A5_5A5A);
    rdchk(ADDR_SIG_LO, 32'hA5A5_5A5A, 32'hFFFF_FFFF, 1'b0);
    // Registers load only on a clock pin rise
    pulse();
    rdchk(ADDR_STATUS, 32'h01FF_00FF, 32'hFFFF_FFFF, 1'b0);
    wr(ADDR_POL, 32'h0000_000F);
    tick(4);
    rdchk(ADDR_STATUS, 32'h01FF_00FF, 32'hFFFF_FFFF, 1'b0);
    pulse();
    rdchk(ADDR_STATUS, 32'h01FF_0FF0, 32'hFFFF_FFFF, 1'b0);
    oeReqN <= 1'b1;
    tick(5);
    // Registered mode still reads back in the mode field
    rdchk(ADDR_STATUS, 32'h0100_00F0, 32'hFFFF_00FF, 1'b0);
    // Preload, full and partial select; the register reads back zero
    wr(ADDR_PRELOAD, 32'h0000_FF3C);
    tick(4);
    wr(ADDR_PRELOAD, 32'h0000_0F00);
    tick(4);
    rdchk(ADDR_STATUS, 32'h0000_0030, 32'h0000_00FF, 1'b0);
    rdchk(ADDR_PRELOAD, 32'h0, 32'hFFFF_FFFF, 1'b0);
    // Cells 0,1 keep only their first term; cell 2 sums two feedback terms
    wr(ADDR_POL, 32'h0);
    wr(ADDR_TDIS_LO, 32'h00FC_FEFE);
    wr(12'h180, 32'h0000_1000);
    wr(12'h188, 32'h0000_1000);
    oeReqN <= 1'b0;
    pulse();
    rdchk(ADDR_STATUS, 32'h0000_0003, 32'h0000_0003, 1'b0);
    wr(ADDR_CFG, 32'h0000_0002);
    oeReqN <= 1'b1;
    tick(5);
    rdchk(ADDR_STATUS, 32'h0002_0000, 32'h00FF_0200, 1'b0);
    wr(ADDR_TDIS_LO, 32'h00FC_FFFE);
    tick(4);
    rdchk(ADDR_STATUS, 32'h0, 32'h00FF_0000, 1'b0);
    // Complex: clock pin is data through slot 0, term zero drives enable
    wr(ADDR_MODE, 32'h0000_0003);
    wr(ADDR_PRELOAD, 32'h0000_FFA5);
    pulse();
    clkReq <= 1'b1;
    tick(5);
    rdchk(ADDR_STATUS, 32'h02FD_FCA5, 32'h07FF_FDFF, 1'b0);
    clkReq <= 1'b0;
    tick(5);
    rdchk(ADDR_STATUS, 32'h00F9_0000, 32'h00FF_0000, 1'b0);
    // Simple: slot 1 reads pin 0, centre cells stay outputs
    wr(ADDR_MODE, 32'h0000_0001);
    wr(ADDR_CFG, 32'h0000_0019);
    wr(ADDR_POL, 32'h0000_0080);
    wr(12'h180, 32'h0000_2000);
    wr(12'h188, 32'h0000_2000);
    extEn  <= 8'h01;
    extVal <= 8'h01;
    tick(5);
    rdchk(ADDR_STATUS, 32'h04FE_7C00, 32'h07FF_FE00, 1'b0);
    extVal <= 8'h00;
    tick(5);
    rdchk(ADDR_STATUS, 32'h0, 32'h0000_0400, 1'b0);
    conclude();
  end
endmodule : tb_top
